// ==== core/tsm_field_engine.sv ====
`timescale 1ns/1ps

// Summary of operation
// - Search table leftward; stop on match or short.
// - Relationship code selects search stop condition.
// - Short field leaves indicators at stored greater.
// - Short forms reuse the previously held variant.
// - Omitted addresses come from operand address registers.
// - A match leaves B at value, A past argument.
// - Low digit zero moves nothing, still steps.
// - Low digit selects copied bit groups.
// - High digit zero moves one character, decrements.
// - Digit one: forward, stop on either mark.
// - Digit two: backward, stop on source mark.
// - Digits three, five, seven stop on controls.
// - Digit four: backward, stop on destination mark.
// - Digit six: backward, stop on either mark.
// - Omitted destination uses B register contents.
// - Terminating character is handled like the rest.
module tsm_field_engine
    import tsm_pkg::*;
#(
    parameter int ADDR_W = 19 // Main memory address width
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic start, // One-cycle request
    input wire logic op_move, // 0 table search, 1 move or scan
    input wire logic [1:0] fmt, // Instruction form
    input wire logic [5:0] cmd_variant, // Variant of a full form
    input wire logic [ADDR_W-1:0] cmd_a_addr, // A address field
    input wire logic [ADDR_W-1:0] cmd_b_addr, // B address field
    output logic busy, // Instruction in progress
    output logic done, // One-cycle completion pulse
    // Processor state seen by the rest of the processor
    output logic [ADDR_W-1:0] a_operand_address_reg,
    output logic [ADDR_W-1:0] b_operand_address_reg,
    output logic [5:0] variant_reg,
    output logic cmp_less, // Stored below search
    output logic cmp_equal, // Stored equal to search
    output logic cmp_greater, // Stored above search
    // Main memory, one character per cycle, read data one cycle later
    output logic mem_rd,
    output logic mem_wr,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [TSM_CHAR_W-1:0] mem_wdata,
    input wire logic [TSM_CHAR_W-1:0] mem_rdata
);

    // Registered state; next values
    // come from the comb block below
    tsm_state_e state, next_state; // Sequencer
    logic [ADDR_W-1:0] a_ptr, next_a_ptr; // Working A position
    logic [ADDR_W-1:0] b_ptr, next_b_ptr; // Working B position
    logic [ADDR_W-1:0] a_start, next_a_start; // Rightmost search character
    logic [ADDR_W-1:0] a_reg, next_a_reg; // A operand address register
    logic [ADDR_W-1:0] b_reg, next_b_reg; // B operand address register
    logic [5:0] var_q, next_var_q; // Variant register
    logic [5:0] code, next_code; // Variant in force for this instruction
    logic [7:0] a_char, next_a_char; // Latched source or search character
    logic [7:0] wbuf, next_wbuf; // Merged character awaiting write
    logic mv_stop, next_mv_stop; // Last character of the move
    logic [1:0] rel, next_rel; // Running comparison of current field
    logic [2:0] ind, next_ind; // Indicators: greater, equal, less

    // Combinational helpers
    logic [1:0] ev_rel; // Comparison including the character in hand
    logic rel_hit; // Finished argument meets the relationship
    logic [7:0] mv_merged; // Move unit result
    logic mv_end; // Move unit end condition
    logic mv_up; // Move runs left to right
    logic mv_writes; // Move transfers bits

    // Relationship check on the comparison as it stands after this character
    tsm_relation u_relation (
        .code(code),
        .rel(ev_rel),
        .hit(rel_hit)
    );

    // Bit merge and end sensing for moves
    tsm_move_unit u_move (
        .code(code),
        .src_char(a_char),
        .dst_char(mem_rdata),
        .merged(mv_merged),
        .stop(mv_end),
        .ascend(mv_up),
        .writes(mv_writes)
    );

    // Leftmost difference decides, so a later (more leftward) mismatch overrides
    always_comb begin
        if (mem_rdata[TSM_DATA_MSB:0] < a_char[TSM_DATA_MSB:0]) begin
            ev_rel = TSM_CMP_LT;
        end else if (mem_rdata[TSM_DATA_MSB:0] > a_char[TSM_DATA_MSB:0]) begin
            ev_rel = TSM_CMP_GT;
        end else begin
            ev_rel = rel;
        end
    end

    // Memory strobes; at most one access per cycle
    always_comb begin
        mem_rd = (state == TSM_ST_TS_RA) || (state == TSM_ST_TS_RB) || (state == TSM_ST_TS_SK)
            || (state == TSM_ST_MV_RA) || (state == TSM_ST_MV_RB);
        mem_wr = (state == TSM_ST_MV_WR) && mv_writes;
        if ((state == TSM_ST_TS_RA) || (state == TSM_ST_MV_RA)) begin
            mem_addr = a_ptr;
        end else begin
            mem_addr = b_ptr;
        end
    end

    // Outputs straight from registers
    assign mem_wdata = wbuf;
    assign busy = (state != TSM_ST_IDLE);
    assign done = (state == TSM_ST_DONE);
    assign a_operand_address_reg = a_reg;
    assign b_operand_address_reg = b_reg;
    assign variant_reg = var_q;
    assign cmp_greater = ind[2];
    assign cmp_equal = ind[1];
    assign cmp_less = ind[0];

    // Next-state and datapath computation
    always_comb begin
        // Hold everything unless a
        // state below says otherwise
        next_state = state;
        next_a_ptr = a_ptr;
        next_b_ptr = b_ptr;
        next_a_start = a_start;
        next_a_reg = a_reg;
        next_b_reg = b_reg;
        next_var_q = var_q;
        next_code = code;
        next_a_char = a_char;
        next_wbuf = wbuf;
        next_mv_stop = mv_stop;
        next_rel = rel;
        next_ind = ind;
        case (state)
            TSM_ST_IDLE: begin
                // Wait for a request
                if (start) begin
                    // Full form loads the variant, short forms reuse it
                    if (fmt == TSM_FMT_A) begin
                        next_var_q = cmd_variant;
                        next_code = cmd_variant;
                    end else begin
                        next_code = var_q;
                    end
                    // Omitted addresses come from the address registers
                    next_a_ptr = (fmt == TSM_FMT_D) ? a_reg : cmd_a_addr;
                    next_b_ptr = ((fmt == TSM_FMT_C) || (fmt == TSM_FMT_D)) ? b_reg : cmd_b_addr;
                    next_a_start = next_a_ptr;
                    next_rel = TSM_CMP_EQ;
                    next_state = op_move ? TSM_ST_MV_RA : TSM_ST_TS_RA;
                end
            end

            // Table search: read search character, then table character
            TSM_ST_TS_RA: begin
                // Search char due next edge
                next_state = TSM_ST_TS_RB;
            end
            TSM_ST_TS_RB: begin
                // Search char on the bus
                next_a_char = mem_rdata;
                next_state = TSM_ST_TS_EV;
            end

            TSM_ST_TS_EV: begin
                // Table char on the bus
                next_rel = ev_rel;
                next_a_ptr = a_ptr - 1'b1;
                next_b_ptr = b_ptr - 1'b1;
                if (mem_rdata[TSM_WM_BIT] && !a_char[TSM_WM_BIT]) begin
                    // Table field ended before the argument: short field
                    next_ind = 3'b100;
                    next_a_reg = a_ptr - 1'b1;
                    next_b_reg = b_ptr - 1'b1;
                    next_state = TSM_ST_DONE;
                end else if (a_char[TSM_WM_BIT]) begin
                    // Whole argument compared; relies on equal-length arguments
                    if (rel_hit) begin
                        next_ind = {ev_rel == TSM_CMP_GT, ev_rel == TSM_CMP_EQ, ev_rel == TSM_CMP_LT};
                        next_a_reg = a_ptr - 1'b1;
                        next_b_reg = b_ptr - 1'b1;
                        next_state = TSM_ST_DONE;
                    end else begin
                        next_a_ptr = a_start;
                        next_rel = TSM_CMP_EQ;
                        // Field without value goes straight to the next one
                        next_state = mem_rdata[TSM_WM_BIT] ? TSM_ST_TS_RA : TSM_ST_TS_SK;
                    end
                end else begin
                    next_state = TSM_ST_TS_RA;
                end
            end

            // Skip the value part of a rejected field up to its word mark
            TSM_ST_TS_SK: begin
                next_state = TSM_ST_TS_SE;
            end

            TSM_ST_TS_SE: begin
                // Value char on the bus
                next_b_ptr = b_ptr - 1'b1;
                next_state = mem_rdata[TSM_WM_BIT] ? TSM_ST_TS_RA : TSM_ST_TS_SK;
            end

            // Move or scan: read source, read destination, merge, write
            TSM_ST_MV_RA: begin
                // Source char due next edge
                next_state = TSM_ST_MV_RB;
            end

            TSM_ST_MV_RB: begin
                // Source char on the bus
                next_a_char = mem_rdata;
                next_state = TSM_ST_MV_EV;
            end

            TSM_ST_MV_EV: begin
                // Terminating character is merged like any other
                next_wbuf = mv_merged;
                next_mv_stop = mv_end;
                next_state = TSM_ST_MV_WR;
            end

            TSM_ST_MV_WR: begin
                // Pointers step even when no bits move
                if (mv_up) begin
                    next_a_ptr = a_ptr + 1'b1;
                    next_b_ptr = b_ptr + 1'b1;
                end else begin
                    next_a_ptr = a_ptr - 1'b1;
                    next_b_ptr = b_ptr - 1'b1;
                end
                if (mv_stop) begin
                    next_a_reg = next_a_ptr;
                    next_b_reg = next_b_ptr;
                    next_state = TSM_ST_DONE;
                end else begin
                    next_state = TSM_ST_MV_RA;
                end
            end

            TSM_ST_DONE: begin
                // Completion pulse, then idle
                next_state = TSM_ST_IDLE;
            end

            default: begin
                // Unused codes recover to idle
                next_state = TSM_ST_IDLE;
            end
        endcase
    end

    // Reset clears every register
    // State registers; constants only under reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= TSM_ST_IDLE;
            a_ptr <= '0;
            b_ptr <= '0;
            a_start <= '0;
            a_reg <= '0;
            b_reg <= '0;
            var_q <= TSM_VARIANT_RST;
            code <= TSM_VARIANT_RST;
            a_char <= 8'h00;
            wbuf <= 8'h00;
            mv_stop <= 1'b0;
            rel <= TSM_CMP_EQ;
            ind <= 3'b000;
        end else begin
            state <= next_state;
            a_ptr <= next_a_ptr;
            b_ptr <= next_b_ptr;
            a_start <= next_a_start;
            a_reg <= next_a_reg;
            b_reg <= next_b_reg;
            var_q <= next_var_q;
            code <= next_code;
            a_char <= next_a_char;
            wbuf <= next_wbuf;
            mv_stop <= next_mv_stop;
            rel <= next_rel;
            ind <= next_ind;
        end
    end

endmodule

// ==== core/tsm_pkg.sv ====
package tsm_pkg;

    // Character layout: word mark, item mark, zone pair, numeric quad
    localparam int TSM_CHAR_W = 8;
    localparam int TSM_WM_BIT = 7;
    localparam int TSM_IM_BIT = 6;
    localparam int TSM_DATA_MSB = 5;

    // Bit groups selected by the low move code digit
    localparam logic [7:0] TSM_MASK_NONE = 8'h00;
    localparam logic [7:0] TSM_MASK_NUM = 8'h0F;
    localparam logic [7:0] TSM_MASK_ZONE = 8'h30;
    localparam logic [7:0] TSM_MASK_DATA_IM = 8'h7F;
    localparam logic [7:0] TSM_MASK_WM = 8'h80;
    localparam logic [7:0] TSM_MASK_NUM_WM = 8'h8F;
    localparam logic [7:0] TSM_MASK_ZONE_WM = 8'hB0;
    localparam logic [7:0] TSM_MASK_ALL = 8'hFF;

    // Source control characters that end a forward move
    localparam logic [5:0] TSM_CTRL_AT = 6'h3A;
    localparam logic [5:0] TSM_CTRL_SEMI = 6'h1A;

    // Reset values
    localparam logic [5:0] TSM_VARIANT_RST = 6'h00;

    // Table search relationship codes
    localparam logic [5:0] TSM_REL_LT = 6'h01;
    localparam logic [5:0] TSM_REL_EQ = 6'h02;
    localparam logic [5:0] TSM_REL_LE = 6'h03;
    localparam logic [5:0] TSM_REL_GT = 6'h04;
    localparam logic [5:0] TSM_REL_NE = 6'h05;
    localparam logic [5:0] TSM_REL_GE = 6'h06;

    // Stored-against-search comparison outcome
    typedef enum logic [1:0] {
        TSM_CMP_EQ = 2'b00,
        TSM_CMP_LT = 2'b01,
        TSM_CMP_GT = 2'b10
    } tsm_cmp_e;

    // Instruction forms: full, variant omitted, B omitted, A and B omitted
    typedef enum logic [1:0] {
        TSM_FMT_A = 2'b00,
        TSM_FMT_B = 2'b01,
        TSM_FMT_C = 2'b10,
        TSM_FMT_D = 2'b11
    } tsm_fmt_e;

    // Sequencer states
    typedef enum logic [3:0] {
        TSM_ST_IDLE = 4'b0000,
        TSM_ST_TS_RA = 4'b0001,
        TSM_ST_TS_RB = 4'b0010,
        TSM_ST_TS_EV = 4'b0011,
        TSM_ST_TS_SK = 4'b0100,
        TSM_ST_TS_SE = 4'b0101,
        TSM_ST_MV_RA = 4'b0110,
        TSM_ST_MV_RB = 4'b0111,
        TSM_ST_MV_EV = 4'b1000,
        TSM_ST_MV_WR = 4'b1001,
        TSM_ST_DONE = 4'b1010
    } tsm_state_e;

endpackage

// ==== core/tsm_relation.sv ====
`timescale 1ns/1ps

// Decides whether a finished table argument meets the requested relationship
module tsm_relation
    import tsm_pkg::*;
(
    input wire logic [5:0] code,
    input wire logic [1:0] rel,
    output logic hit
);

    // Relationship decode; unknown codes never stop the search
    always_comb begin
        case (code)
            TSM_REL_LT: hit = (rel == TSM_CMP_LT);
            TSM_REL_EQ: hit = (rel == TSM_CMP_EQ);
            TSM_REL_LE: hit = (rel != TSM_CMP_GT);
            TSM_REL_GT: hit = (rel == TSM_CMP_GT);
            TSM_REL_NE: hit = (rel != TSM_CMP_EQ);
            TSM_REL_GE: hit = (rel != TSM_CMP_LT);
            default: hit = 1'b0;
        endcase
    end

endmodule

// ==== core/tsm_move_unit.sv ====
`timescale 1ns/1ps

// Merges one source character into one destination character and decides the end
module tsm_move_unit
    import tsm_pkg::*;
(
    input wire logic [5:0] code,
    input wire logic [7:0] src_char,
    input wire logic [7:0] dst_char,
    output logic [7:0] merged,
    output logic stop,
    output logic ascend,
    output logic writes
);

    logic [7:0] mask; // Bits taken from the source
    logic src_wm; // Source word mark
    logic dst_wm; // Destination word mark
    logic src_at; // Source holds the 72 octal control
    logic src_semi; // Source holds 32 octal with word mark

    assign src_wm = src_char[TSM_WM_BIT];
    assign dst_wm = dst_char[TSM_WM_BIT];
    assign src_at = (src_char[TSM_DATA_MSB:0] == TSM_CTRL_AT);
    assign src_semi = (src_char[TSM_DATA_MSB:0] == TSM_CTRL_SEMI) && src_wm;

    // Bit group selection by the low digit
    always_comb begin
        case (code[2:0])
            3'h1: mask = TSM_MASK_NUM;
            3'h2: mask = TSM_MASK_ZONE;
            3'h3: mask = TSM_MASK_DATA_IM;
            3'h4: mask = TSM_MASK_WM;
            3'h5: mask = TSM_MASK_NUM_WM;
            3'h6: mask = TSM_MASK_ZONE_WM;
            3'h7: mask = TSM_MASK_ALL;
            default: mask = TSM_MASK_NONE;
        endcase
        merged = (dst_char & ~mask) | (src_char & mask);
        writes = (code[2:0] != 3'h0);
    end

    // Direction and end condition by the high digit
    always_comb begin
        case (code[5:3])
            3'h0: begin
                stop = 1'b1;
                ascend = 1'b0;
            end
            3'h1: begin
                stop = src_wm || dst_wm;
                ascend = 1'b1;
            end
            3'h2: begin
                stop = src_wm;
                ascend = 1'b0;
            end
            3'h3: begin
                stop = src_at;
                ascend = 1'b1;
            end
            3'h4: begin
                stop = dst_wm;
                ascend = 1'b0;
            end
            3'h5: begin
                stop = src_semi;
                ascend = 1'b1;
            end
            3'h6: begin
                stop = src_wm || dst_wm;
                ascend = 1'b0;
            end
            default: begin
                stop = src_at || src_semi;
                ascend = 1'b1;
            end
        endcase
    end

endmodule

// ==== tb/tsm_mem_model.sv ====
`timescale 1ns/1ps

// Main memory of character fields, one access per cycle, read data one cycle later
module tsm_mem_model
    import tsm_pkg::*;
#(
    parameter int ADDR_W = 19 // Address width of the engine
) (
    input wire logic sys_clk,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [TSM_CHAR_W-1:0] mem_wdata,
    output logic [TSM_CHAR_W-1:0] mem_rdata
);
    logic [7:0] mem [0:255]; // Only the low 256 places are backed
    logic [7:0] rdata_q = 8'h5A; // Read return register

    // Read answers next cycle; otherwise the bus flips so stale data never matches
    always @(posedge sys_clk) begin
        if (mem_wr) begin
            mem[mem_addr[7:0]] <= mem_wdata;
        end
        if (mem_rd) begin
            rdata_q <= mem[mem_addr[7:0]];
        end else begin
            rdata_q <= ~rdata_q;
        end
    end

    assign mem_rdata = rdata_q;
endmodule

// ==== tb/tsm_field_engine_asserts.sv ====
`timescale 1ns/1ps

// Port-level checks on the field engine
module tsm_field_engine_asserts
    import tsm_pkg::*;
#(
    parameter int ADDR_W = 19 // Same as the engine
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic op_move,
    input wire logic [1:0] fmt,
    input wire logic [5:0] cmd_variant,
    input wire logic [ADDR_W-1:0] cmd_a_addr,
    input wire logic [ADDR_W-1:0] cmd_b_addr,
    input wire logic busy,
    input wire logic done,
    input wire logic [ADDR_W-1:0] a_operand_address_reg,
    input wire logic [ADDR_W-1:0] b_operand_address_reg,
    input wire logic [5:0] variant_reg,
    input wire logic cmp_less,
    input wire logic cmp_equal,
    input wire logic cmp_greater,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [TSM_CHAR_W-1:0] mem_wdata,
    input wire logic [TSM_CHAR_W-1:0] mem_rdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic is_move; // Kind of the running instruction
    logic [5:0] code; // Effective variant of the running instruction
    logic [ADDR_W-1:0] a_at; // Effective A start
    logic [ADDR_W-1:0] b_at; // Effective B start

    // Capture what an accepted request means, since the inputs drop after one cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            is_move <= 1'b0;
            code <= 6'h00;
            a_at <= '0;
            b_at <= '0;
        end else if (start && !busy) begin
            is_move <= op_move;
            code <= (fmt == 2'b00) ? cmd_variant : variant_reg;
            a_at <= (fmt == 2'b11) ? a_operand_address_reg : cmd_a_addr;
            b_at <= fmt[1] ? b_operand_address_reg : cmd_b_addr;
        end
    end

    chk_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
    chk_strobe_excl: assert property (!(mem_rd && mem_wr)) else $error("read and write together");
    chk_start_busy: assert property (start && !busy |=> busy) else $error("start not taken");
    chk_done_bound: assert property (start && !busy |=> ##[1:600] done) else $error("no done");
    chk_ind_onehot: assert property (done && !is_move |-> $onehot({cmp_less, cmp_equal, cmp_greater}))
        else $error("indicators not one-hot after search");
    chk_move_keeps: assert property (busy && is_move |=> $stable({cmp_less, cmp_equal, cmp_greater}))
        else $error("move changed indicators");
    chk_variant_keep: assert property (start && !busy && fmt != 2'b00 |=> variant_reg == $past(variant_reg))
        else $error("short form changed variant");
    chk_zero_nowrite: assert property (busy && is_move && code[2:0] == 3'b000 |-> !mem_wr)
        else $error("write with low digit zero");
    chk_one_char: assert property (done && is_move && code[5:3] == 3'b000 |->
        a_operand_address_reg == ADDR_W'(a_at - 1) && b_operand_address_reg == ADDR_W'(b_at - 1))
        else $error("single move steps wrong");
endmodule

bind tsm_field_engine tsm_field_engine_asserts #(.ADDR_W(ADDR_W)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .start(start), .op_move(op_move), .fmt(fmt), .cmd_variant(cmd_variant), .cmd_a_addr(cmd_a_addr),
    .cmd_b_addr(cmd_b_addr), .busy(busy), .done(done), .a_operand_address_reg(a_operand_address_reg),
    .b_operand_address_reg(b_operand_address_reg), .variant_reg(variant_reg), .cmp_less(cmp_less),
    .cmp_equal(cmp_equal), .cmp_greater(cmp_greater), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

// ==== tb/tsm_field_engine_test.sv ====
`timescale 1ns/1ps

// Self-checking bench for the search and move engine
module tsm_field_engine_test;
    import tsm_pkg::*;
    localparam int AW = 19;
    localparam logic [7:0] MASKS [8] = '{TSM_MASK_NONE, TSM_MASK_NUM, TSM_MASK_ZONE, TSM_MASK_DATA_IM,
        TSM_MASK_WM, TSM_MASK_NUM_WM, TSM_MASK_ZONE_WM, TSM_MASK_ALL};

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic op_move = 1'b0;
    logic [1:0] fmt = 2'b00;
    logic [5:0] cmd_variant = 6'h00;
    logic [AW-1:0] cmd_a_addr = '0;
    logic [AW-1:0] cmd_b_addr = '0;
    logic busy, done, cmp_less, cmp_equal, cmp_greater, mem_rd, mem_wr;
    logic [AW-1:0] a_reg, b_reg, mem_addr;
    logic [5:0] variant_reg;
    logic [7:0] mem_wdata, mem_rdata;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;

    // 25 MHz
    always #20 sys_clk = ~sys_clk;

    tsm_field_engine #(.ADDR_W(AW)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .start(start), .op_move(op_move),
        .fmt(fmt), .cmd_variant(cmd_variant), .cmd_a_addr(cmd_a_addr), .cmd_b_addr(cmd_b_addr), .busy(busy),
        .done(done), .a_operand_address_reg(a_reg), .b_operand_address_reg(b_reg), .variant_reg(variant_reg),
        .cmp_less(cmp_less), .cmp_equal(cmp_equal), .cmp_greater(cmp_greater), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    tsm_mem_model #(.ADDR_W(AW)) u_mem (.sys_clk(sys_clk), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    task automatic bad(input logic [AW-1:0] exp, input logic [AW-1:0] got);
        err_total++;
        $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    endtask

    task automatic chk_addr(input logic [AW-1:0] exp, input logic [AW-1:0] got);
        n_compared++;
        if (got !== exp) bad(exp, got);
    endtask

    task automatic chk_char(input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) bad(AW'(exp), AW'(got));
    endtask

    task automatic chk_ind(input logic [2:0] exp);
        n_compared++;
        if ({cmp_less, cmp_equal, cmp_greater} !== exp) bad(AW'(exp), AW'({cmp_less, cmp_equal, cmp_greater}));
    endtask

    // Issue one instruction and wait for its completion pulse
    task automatic run(input logic op, input logic [1:0] f, input logic [5:0] v, input int a, input int b);
        int n;
        @(negedge sys_clk);
        op_move = op;
        fmt = f;
        cmd_variant = v;
        cmd_a_addr = AW'(a);
        cmd_b_addr = AW'(b);
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 1000) bad('0, AW'(n));
    endtask

    // Every low digit with one-character moves
    task automatic t_one_char();
        for (int k = 0; k < 8; k++) begin
            u_mem.mem[10] = 8'hE9;
            u_mem.mem[20] = 8'h16;
            run(1'b1, 2'b00, 6'(k), 10, 20);
            chk_char((8'h16 & ~MASKS[k]) | (8'hE9 & MASKS[k]), u_mem.mem[20]);
            chk_addr(AW'(9), a_reg);
            chk_addr(AW'(19), b_reg);
        end
        $display("one character moves done");
    endtask

    // Forward move ends on the source word mark, that character included
    task automatic t_forward();
        u_mem.mem[30] = 8'h01;
        u_mem.mem[31] = 8'h02;
        u_mem.mem[32] = 8'h83;
        u_mem.mem[33] = 8'h04;
        for (int i = 40; i < 44; i++) u_mem.mem[i] = 8'h00;
        run(1'b1, 2'b00, 6'o17, 30, 40);
        chk_char(8'h83, u_mem.mem[42]);
        chk_char(8'h00, u_mem.mem[43]);
        chk_addr(AW'(33), a_reg);
        chk_addr(AW'(43), b_reg);
        $display("forward move done");
    endtask

    // Backward moves: code, source mark place, destination mark place, count
    task automatic t_backward();
        int cs [4][4] = '{'{8'o27, 52, 61, 2}, '{8'o47, 52, 61, 3}, '{8'o67, 52, 61, 2}, '{8'o67, 51, 62, 2}};
        int n;
        for (int c = 0; c < 4; c++) begin
            for (int i = 50; i < 54; i++) u_mem.mem[i] = (i == cs[c][1]) ? 8'h91 : 8'h11;
            for (int i = 60; i < 64; i++) u_mem.mem[i] = (i == cs[c][2]) ? 8'hA2 : 8'h22;
            n = cs[c][3];
            run(1'b1, 2'b00, 6'(cs[c][0]), 53, 63);
            chk_char(((54 - n) == cs[c][1]) ? 8'h91 : 8'h11, u_mem.mem[64 - n]);
            chk_char(((63 - n) == cs[c][2]) ? 8'hA2 : 8'h22, u_mem.mem[63 - n]);
            chk_addr(AW'(53 - n), a_reg);
            chk_addr(AW'(63 - n), b_reg);
        end
        $display("backward moves done");
    endtask

    // Control character stops, then the fully omitted form on the held variant
    task automatic t_controls();
        logic [7:0] src [4] = '{8'h01, 8'h1A, 8'h3A, 8'h9A};
        int cs [3][2] = '{'{8'o37, 3}, '{8'o57, 4}, '{8'o77, 3}};
        for (int c = 0; c < 3; c++) begin
            for (int i = 0; i < 4; i++) u_mem.mem[70 + i] = src[i];
            for (int i = 80; i < 85; i++) u_mem.mem[i] = 8'h00;
            run(1'b1, 2'b00, 6'(cs[c][0]), 70, 80);
            chk_char(src[cs[c][1] - 1], u_mem.mem[79 + cs[c][1]]);
            chk_char(8'h00, u_mem.mem[80 + cs[c][1]]);
            chk_addr(AW'(70 + cs[c][1]), a_reg);
            chk_addr(AW'(80 + cs[c][1]), b_reg);
        end
        run(1'b1, 2'b11, 6'o01, 0, 0);
        chk_char(8'h9A, u_mem.mem[83]);
        chk_addr(AW'(74), a_reg);
        chk_addr(AW'(84), b_reg);
        run(1'b1, 2'b10, 6'o01, 70, 0);
        chk_char(8'h3A, u_mem.mem[86]);
        $display("control stops done");
    endtask

    // Table search over every relationship code, then a variant-omitted search
    task automatic t_search();
        logic [7:0] tbl [12] = '{8'h80, 8'h00, 8'h88, 8'h08, 8'h05, 8'h05, 8'h07, 8'h89, 8'h09, 8'h01, 8'h02, 8'h03};
        logic [2:0] ind [6] = '{3'b100, 3'b010, 3'b100, 3'b001, 3'b100, 3'b010};
        int bv [6] = '{146, 141, 146, 0, 146, 141};
        u_mem.mem[100] = 8'h85; // Search argument carries its word mark
        u_mem.mem[101] = 8'h05;
        u_mem.mem[102] = 8'h07;
        for (int i = 0; i < 12; i++) u_mem.mem[138 + i] = tbl[i]; // Equal-length arguments, short end
        for (int c = 0; c < 6; c++) begin
            run(1'b0, 2'b00, 6'(c + 1), 102, 149);
            chk_ind(ind[c]);
            if (bv[c] != 0) begin
                chk_addr(AW'(bv[c]), b_reg);
                chk_addr(AW'(99), a_reg);
            end
        end
        run(1'b0, 2'b01, 6'o01, 102, 149);
        chk_ind(3'b010);
        chk_addr(AW'(141), b_reg);
        $display("table search done");
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Cut a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        for (int i = 0; i < 256; i++) u_mem.mem[i] = 8'h00;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        t_one_char();
        t_forward();
        t_backward();
        t_controls();
        t_search();
        test_done();
    end
endmodule
